// >>> hw/rtq_dev.sv
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "rtq_map.svh"

module rtq_dev #(
  parameter int unsigned TCYC0_CYC = 32'(`RTQ_TCYC0_CYC),
  parameter int unsigned TCYC1_CYC = 32'(`RTQ_TCYC1_CYC)
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Host link
  rtq_if.dev               link,
  // Measurement front end
  input  wire logic        lf_clk_in,
  input  wire logic        sense_stop_in,
  output logic             discharge_en,
  output logic [1:0]       port_sel,
  // Oscillator and flight sequencing
  input  wire logic        nvm_req,
  input  wire logic        flight_done,
  output logic             hs_osc_en,
  output logic             flight_go
);

  // ========================================================================
  // Helpers
  // ========================================================================
  function automatic logic [10:0] settle_ticks(input logic [2:0] osc);
    case (osc)
      3'h2:    settle_ticks = `RTQ_NS2TK(`RTQ_SET0_NS);
      3'h3:    settle_ticks = `RTQ_NS2TK(`RTQ_SET1_NS);
      3'h4:    settle_ticks = `RTQ_NS2TK(`RTQ_SET2_NS);
      default: settle_ticks = `RTQ_NS2TK(`RTQ_SET3_NS);
    endcase
  endfunction : settle_ticks

  // Half mains periods, so that factors 1, 1.5, 2, 2.5 are whole counts.
  function automatic logic [10:0] mains_ticks(input logic sixty,
                                              input logic [1:0] fact);
    logic [10:0] half;
    logic [2:0]  mult;
    half = sixty ? `RTQ_NS2TK(`RTQ_HALF60_NS)
                 : `RTQ_NS2TK(`RTQ_HALF50_NS);
    mult = {1'b0, fact} + 3'h2;
    mains_ticks = 11'(mult * half);
  endfunction : mains_ticks

  function automatic logic [3:0] dummy_num(input logic many);
    dummy_num = many ? `RTQ_DUMMY_MANY : `RTQ_DUMMY_FEW;
  endfunction : dummy_num

  function automatic logic [1:0] port_of(input logic [3:0] k,
                                         input logic [3:0] ndum,
                                         input logic       desc);
    logic [1:0] j;
    j = (k < ndum) ? 2'h0 : 2'(k - ndum);
    port_of = desc ? 2'h3 - j : j;
  endfunction : port_of

  // ========================================================================
  // State
  // ========================================================================
  rtq_pkg::rtq_dev_t s;
  rtq_pkg::rtq_dev_t next_s;

  logic        stop_lvl;
  logic        stop_edge;
  logic        lf_tick;
  logic [3:0]  ndum;
  logic [3:0]  last_k;
  logic [23:0] limit;
  logic [31:0] value;

  assign discharge_en   = s.dis_en;
  assign port_sel       = s.port_sel;
  assign hs_osc_en      = s.hs_en;
  assign flight_go      = s.flight_go;
  assign link.busy      = s.busy;
  assign link.done_flag = s.done_flag;
  assign link.res       = s.res;

  always_comb begin
    next_s = s;
    next_s.flight_go = 1'b0;

    // Pins pass three flip-flops; a change counts once two and three agree.
    next_s.ss = {s.ss[1:0], sense_stop_in};
    next_s.ls = {s.ls[1:0], lf_clk_in};
    if (s.ss[1] == s.ss[2]) begin
      next_s.stop_f = s.ss[2];
    end
    if (s.ls[1] == s.ls[2]) begin
      next_s.lf_f = s.ls[2];
    end
    // Stops count only while the start input is enabled.
    stop_lvl  = next_s.stop_f ^ s.cfg.sense_stop_invert;
    stop_edge = stop_lvl & ~(s.stop_f ^ s.cfg.sense_stop_invert)
                & link.start_en;
    lf_tick   = next_s.lf_f & ~s.lf_f;

    ndum   = dummy_num(s.cfg.dummy_count_sel);
    last_k = ndum + (s.cfg.port_count_sel ? `RTQ_PORTS_FOUR
                                          : `RTQ_PORTS_TWO) - 4'h1;
    limit  = s.cfg.tcycle_sel ? 24'(TCYC1_CYC)
                              : 24'(TCYC0_CYC);
    value  = 32'(s.cnt);

    case (s.st)
      rtq_pkg::RTQ_IDLE: begin
        if (link.cmd_valid && link.cmd_op != rtq_pkg::RTQ_OP_NONE) begin
          next_s.cfg  = link.cfg;
          next_s.rpt  = link.cmd_op == rtq_pkg::RTQ_OP_TEMP_RPT ||
                        link.cmd_op == rtq_pkg::RTQ_OP_FLIGHT_RPT;
          next_s.temp = link.cmd_op == rtq_pkg::RTQ_OP_TEMP ||
                        link.cmd_op == rtq_pkg::RTQ_OP_TEMP_RPT;
          next_s.busy      = 1'b1;
          next_s.done_flag = 1'b0;
          next_s.st        = rtq_pkg::RTQ_START;
        end
      end
      rtq_pkg::RTQ_START: begin
        next_s.tick = 11'h000;
        if (s.cfg.hs_osc_ctrl > 3'h1) begin
          next_s.hs_on = 1'b1;
          next_s.st    = rtq_pkg::RTQ_SETTLE;
        end else begin
          next_s.st = rtq_pkg::RTQ_RUN;
        end
      end
      rtq_pkg::RTQ_SETTLE: begin
        if (s.tick >= settle_ticks(s.cfg.hs_osc_ctrl)) begin
          next_s.st = rtq_pkg::RTQ_RUN;
        end else if (lf_tick) begin
          next_s.tick = s.tick + 11'h001;
        end
      end
      rtq_pkg::RTQ_RUN: begin
        if (s.temp) begin
          next_s.k        = 4'h0;
          next_s.cnt      = 24'h000000;
          next_s.port_sel = port_of(4'h0, ndum, s.cfg.port_order_sel);
          next_s.dis_en   = 1'b1;
          next_s.st       = rtq_pkg::RTQ_DISCH;
        end else begin
          next_s.flight_go = 1'b1;
          next_s.st        = rtq_pkg::RTQ_FLIGHT;
        end
      end
      rtq_pkg::RTQ_DISCH: begin
        next_s.cnt = s.cnt + 24'h000001;
        if (stop_edge || s.cnt >= limit - 24'h000001) begin
          if (s.k >= ndum) begin
            if (!stop_edge) begin
              value = `RTQ_OPEN_CODE;
            end else if (s.cnt < `RTQ_SHORT_CYC) begin
              value = `RTQ_SHORT_CODE;
            end
            next_s.res[s.port_sel] = value;
          end
          next_s.cnt = 24'h000000;
          if (s.k == last_k) begin
            next_s.dis_en = 1'b0;
            next_s.st     = rtq_pkg::RTQ_END;
          end else begin
            next_s.k        = s.k + 4'h1;
            next_s.port_sel = port_of(s.k + 4'h1, ndum,
                                      s.cfg.port_order_sel);
          end
        end
      end
      rtq_pkg::RTQ_FLIGHT: begin
        if (flight_done) begin
          next_s.st = rtq_pkg::RTQ_END;
        end
      end
      rtq_pkg::RTQ_END: begin
        next_s.hs_on     = 1'b0;
        next_s.done_flag = 1'b1;
        next_s.tick      = 11'h000;
        if (s.rpt) begin
          next_s.rpt = 1'b0;
          next_s.st  = rtq_pkg::RTQ_MAINS;
        end else begin
          next_s.busy = 1'b0;
          next_s.st   = rtq_pkg::RTQ_IDLE;
        end
      end
      rtq_pkg::RTQ_MAINS: begin
        if (s.tick >= mains_ticks(s.cfg.mains_base_sel,
                                  s.cfg.cycle_factor)) begin
          next_s.st = rtq_pkg::RTQ_START;
        end else if (lf_tick) begin
          next_s.tick = s.tick + 11'h001;
        end
      end
      default: begin
        next_s.st = rtq_pkg::RTQ_IDLE;
      end
    endcase

    // Continuous mode follows the live setting; memory access forces it on.
    next_s.hs_en = next_s.hs_on || nvm_req ||
                   link.cfg.hs_osc_ctrl == 3'h1;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : rtq_dev

// >>> hw/rtq_map.svh
`ifndef RTQ_MAP_SVH
`define RTQ_MAP_SVH

// ==========================================================================
// Clock rates
// ==========================================================================
`define RTQ_CLK_HZ       64'd25000000
`define RTQ_LF_HZ        64'd32768
`define RTQ_NS_PER_S     64'd1000000000

// ==========================================================================
// Discharge timing, counted in system clock cycles
// ==========================================================================
`define RTQ_TCYC0_NS     64'd128000
`define RTQ_TCYC1_NS     64'd512000
`define RTQ_TCYC0_CYC    (`RTQ_TCYC0_NS * `RTQ_CLK_HZ / `RTQ_NS_PER_S)
`define RTQ_TCYC1_CYC    (`RTQ_TCYC1_NS * `RTQ_CLK_HZ / `RTQ_NS_PER_S)
`define RTQ_SHORT_NS     64'd2000
`define RTQ_SHORT_CYC    24'((`RTQ_SHORT_NS * `RTQ_CLK_HZ + `RTQ_NS_PER_S \
                          - 64'd1) / `RTQ_NS_PER_S)

// ==========================================================================
// Oscillator settling and mains delays, counted in 32 kHz ticks
// ==========================================================================
`define RTQ_NS2TK(ns)    11'((ns * `RTQ_LF_HZ + `RTQ_NS_PER_S - 64'd1) \
                          / `RTQ_NS_PER_S)
`define RTQ_SET0_NS      64'd480000
`define RTQ_SET1_NS      64'd1460000
`define RTQ_SET2_NS      64'd2440000
`define RTQ_SET3_NS      64'd5140000
`define RTQ_HALF50_NS    64'd10000000
`define RTQ_HALF60_NS    64'd8333333

// ==========================================================================
// Sequence counts
// ==========================================================================
`define RTQ_DUMMY_FEW    4'h2
`define RTQ_DUMMY_MANY   4'h8
`define RTQ_PORTS_TWO    4'h2
`define RTQ_PORTS_FOUR   4'h4
`define RTQ_OPEN_CODE    32'hFFFFFFFF
`define RTQ_SHORT_CODE   32'h00000000

// ==========================================================================
// Host register map and field positions
// ==========================================================================
`define RTQ_REG_CFG      5'h00
`define RTQ_REG_CMD      5'h04
`define RTQ_REG_STAT     5'h08
`define RTQ_REG_RES0     5'h10
`define RTQ_REG_RES1     5'h14
`define RTQ_REG_RES2     5'h18
`define RTQ_REG_RES3     5'h1C
`define RTQ_CFG_DUMMY    0
`define RTQ_CFG_TCYC     1
`define RTQ_CFG_PORTS    2
`define RTQ_CFG_ORDER    3
`define RTQ_CFG_MAINS    4
`define RTQ_CFG_FACT_LO  5
`define RTQ_CFG_FACT_HI  6
`define RTQ_CFG_INV      7
`define RTQ_CFG_OSC_LO   8
`define RTQ_CFG_OSC_HI   10
`define RTQ_CFG_START_EN 11
`define RTQ_CFG_RST      12'hA82
`define RTQ_STAT_BUSY    0
`define RTQ_STAT_DONE    1

`endif

// >>> hw/rtq_pkg.sv
package rtq_pkg;

  // ========================================================================
  // Opcodes and configuration
  // ========================================================================
  typedef enum logic [2:0] {
    RTQ_OP_NONE       = 3'b000,
    RTQ_OP_TEMP       = 3'b001,
    RTQ_OP_TEMP_RPT   = 3'b010,
    RTQ_OP_FLIGHT     = 3'b011,
    RTQ_OP_FLIGHT_RPT = 3'b100
  } rtq_op_t;

  typedef struct packed {
    logic       dummy_count_sel;
    logic       tcycle_sel;
    logic       port_count_sel;
    logic       port_order_sel;
    logic       mains_base_sel;
    logic [1:0] cycle_factor;
    logic       sense_stop_invert;
    logic [2:0] hs_osc_ctrl;
  } rtq_cfg_t;

  // ========================================================================
  // Device sequencer state
  // ========================================================================
  typedef enum logic [2:0] {
    RTQ_IDLE   = 3'b000,
    RTQ_START  = 3'b001,
    RTQ_SETTLE = 3'b010,
    RTQ_RUN    = 3'b011,
    RTQ_DISCH  = 3'b100,
    RTQ_FLIGHT = 3'b101,
    RTQ_END    = 3'b110,
    RTQ_MAINS  = 3'b111
  } rtq_st_t;

  typedef struct packed {
    rtq_st_t          st;
    rtq_cfg_t         cfg;
    logic             rpt;
    logic             temp;
    logic [23:0]      cnt;
    logic [10:0]      tick;
    logic [3:0]       k;
    logic [2:0]       ss;
    logic [2:0]       ls;
    logic             stop_f;
    logic             lf_f;
    logic             hs_on;
    logic             hs_en;
    logic [1:0]       port_sel;
    logic             dis_en;
    logic             flight_go;
    logic             busy;
    logic             done_flag;
    logic [3:0][31:0] res;
  } rtq_dev_t;

  // ========================================================================
  // Host controller state
  // ========================================================================
  typedef struct packed {
    logic [11:0] cfg;
    logic        cmd_valid;
    rtq_op_t     cmd_op;
    logic [31:0] rdata;
  } rtq_host_t;

endpackage : rtq_pkg

// >>> hw/rtq_if.sv
`timescale 1ns/1ns

interface rtq_if;
  logic                 cmd_valid;
  rtq_pkg::rtq_op_t     cmd_op;
  rtq_pkg::rtq_cfg_t    cfg;
  logic                 start_en;
  logic                 busy;
  logic                 done_flag;
  logic [3:0][31:0]     res;

  modport dev (
    input  cmd_valid,
    input  cmd_op,
    input  cfg,
    input  start_en,
    output busy,
    output done_flag,
    output res
  );

  modport host (
    output cmd_valid,
    output cmd_op,
    output cfg,
    output start_en,
    input  busy,
    input  done_flag,
    input  res
  );
endinterface : rtq_if

// >>> hw/rtq_host.sv
`timescale 1ns/1ns
`include "rtq_map.svh"

module rtq_host (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Device link
  rtq_if.host              link,
  // Software register port
  input  wire logic [4:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata
);

  // ========================================================================
  // State
  // ========================================================================
  rtq_pkg::rtq_host_t s;
  rtq_pkg::rtq_host_t next_s;

  assign link.cmd_valid = s.cmd_valid;
  assign link.cmd_op    = s.cmd_op;
  assign link.start_en  = s.cfg[`RTQ_CFG_START_EN];
  assign link.cfg.dummy_count_sel   = s.cfg[`RTQ_CFG_DUMMY];
  assign link.cfg.tcycle_sel        = s.cfg[`RTQ_CFG_TCYC];
  assign link.cfg.port_count_sel    = s.cfg[`RTQ_CFG_PORTS];
  assign link.cfg.port_order_sel    = s.cfg[`RTQ_CFG_ORDER];
  assign link.cfg.mains_base_sel    = s.cfg[`RTQ_CFG_MAINS];
  assign link.cfg.cycle_factor      =
    s.cfg[`RTQ_CFG_FACT_HI:`RTQ_CFG_FACT_LO];
  assign link.cfg.sense_stop_invert = s.cfg[`RTQ_CFG_INV];
  assign link.cfg.hs_osc_ctrl       = s.cfg[`RTQ_CFG_OSC_HI:`RTQ_CFG_OSC_LO];
  assign rdata = s.rdata;

  always_comb begin
    next_s = s;
    next_s.cmd_valid = 1'b0;
    next_s.cmd_op    = rtq_pkg::RTQ_OP_NONE;
    next_s.rdata     = 32'h00000000;
    if (wr) begin
      case (addr)
        `RTQ_REG_CFG: begin
          next_s.cfg = wdata[11:0];
        end
        `RTQ_REG_CMD: begin
          next_s.cmd_valid = 1'b1;
          next_s.cmd_op    = rtq_pkg::rtq_op_t'(wdata[2:0]);
        end
        default: begin
          next_s.cfg = s.cfg;
        end
      endcase
    end
    if (rd) begin
      case (addr)
        `RTQ_REG_CFG:  next_s.rdata = {20'h00000, s.cfg};
        `RTQ_REG_STAT: next_s.rdata = {30'h0, link.done_flag,
                                       link.busy};
        `RTQ_REG_RES0: next_s.rdata = link.res[0];
        `RTQ_REG_RES1: next_s.rdata = link.res[1];
        `RTQ_REG_RES2: next_s.rdata = link.res[2];
        `RTQ_REG_RES3: next_s.rdata = link.res[3];
        default:       next_s.rdata = 32'h00000000;
      endcase
    end
  end

  // Reset defaults: inverted stop for the on-chip comparator, long cycle,
  // shortest gated settling delay and start input enabled.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s       <= '0;
      s.cfg   <= `RTQ_CFG_RST;
    end else begin
      s <= next_s;
    end
  end

endmodule : rtq_host

// >>> verif/rtq_asserts.sv
`timescale 1ns/1ns

module rtq_asserts #(
  parameter int unsigned TCYC0_CYC = 100,
  parameter int unsigned TCYC1_CYC = 400
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst_b,
  // Link
  input wire logic              cmd_valid,
  input wire rtq_pkg::rtq_op_t  cmd_op,
  input wire rtq_pkg::rtq_cfg_t cfg,
  input wire logic              busy,
  input wire logic              done_flag,
  // Device pins
  input wire logic              discharge_en,
  input wire logic [1:0]        port_sel,
  input wire logic              hs_osc_en,
  input wire logic              nvm_req
);
  // ==========================================================================
  // Helper logic
  // ==========================================================================
  // About 14.4 low-frequency periods, just under the fifteen a 16-tick wait takes at least.
  localparam int SETTLE_MIN = 11000;
  logic              accept;
  rtq_pkg::rtq_cfg_t run_cfg;
  logic              first_dis;
  logic [15:0]       on_cyc;
  logic [15:0]       dis_len;
  logic [15:0]       n_win;
  assign accept = cmd_valid && cmd_op != rtq_pkg::RTQ_OP_NONE && !busy;
  // Discharge stays high across every window of a run, so the run as a
  // whole is bounded by its window count times the cycle limit.
  assign n_win = (run_cfg.dummy_count_sel ? 16'h8 : 16'h2) +
                 (run_cfg.port_count_sel ? 16'h4 : 16'h2);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      run_cfg   <= '0;
      first_dis <= 1'b0;
      on_cyc    <= '0;
      dis_len   <= '0;
    end else begin
      if (accept) begin
        run_cfg   <= cfg;
        first_dis <= 1'b1;
      end else if (discharge_en) begin
        first_dis <= 1'b0;
      end
      on_cyc  <= !hs_osc_en ? '0 : on_cyc + {15'h0, on_cyc != 16'hFFFF};
      dis_len <= discharge_en ? dis_len + 16'h1 : '0;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_START_TAKEN: assert property (accept |=> busy && !done_flag)
    else $error("accepted start did not raise busy");
  AST_END_DONE: assert property ($fell(busy) |-> ##[0:1] done_flag)
    else $error("run ended without done flag");
  AST_DONE_IDLE: assert property ($rose(done_flag) |-> !discharge_en)
    else $error("done flag raised during a discharge");
  AST_TWO_PORTS: assert property (
    discharge_en && !run_cfg.port_count_sel
    |-> port_sel[1] == run_cfg.port_order_sel)
    else $error("port outside the two selected ports");
  AST_FIRST_PORT: assert property (
    $rose(discharge_en) && first_dis
    |-> port_sel == (run_cfg.port_order_sel ? 2'h3 : 2'h0))
    else $error("first discharge on wrong port");
  AST_WIN_SHORT: assert property (
    discharge_en && !run_cfg.tcycle_sel |-> dis_len < n_win * TCYC0_CYC)
    else $error("short cycle window overran");
  AST_WIN_LONG: assert property (
    discharge_en |-> dis_len < n_win * TCYC1_CYC)
    else $error("long cycle window overran");
  AST_SETTLED: assert property (
    $rose(discharge_en) && run_cfg.hs_osc_ctrl > 3'h1
    |-> on_cyc >= SETTLE_MIN)
    else $error("discharge before oscillator settled");
  AST_OSC_DURING: assert property (
    discharge_en && run_cfg.hs_osc_ctrl > 3'h1 |-> hs_osc_en)
    else $error("oscillator off during discharge");
  AST_OSC_GATE_ON: assert property (
    accept && cfg.hs_osc_ctrl > 3'h1 |-> ##[1:4] hs_osc_en)
    else $error("oscillator not switched on at start");
  AST_OSC_RELEASE: assert property (
    $fell(busy) && run_cfg.hs_osc_ctrl > 3'h1 && cfg.hs_osc_ctrl != 3'h1
    && !nvm_req |-> ##[0:2] !hs_osc_en)
    else $error("oscillator left on after run");
  AST_OSC_OFF: assert property (
    (!busy && cfg.hs_osc_ctrl == 3'h0 && !nvm_req)[*4] |-> !hs_osc_en)
    else $error("oscillator on with code zero");
  AST_OSC_CONT: assert property (
    (cfg.hs_osc_ctrl == 3'h1)[*4] |-> hs_osc_en)
    else $error("oscillator off with code one");
  AST_NVM_ON: assert property (nvm_req[*4] |-> hs_osc_en)
    else $error("oscillator off during memory request");
endmodule : rtq_asserts

// >>> verif/rtq_test.sv
`timescale 1ns/1ns

module rtq_test;
  typedef struct packed {
    logic             dm;
    logic             tc;
    logic             pc;
    logic             po;
    logic             iv;
    logic [3:0][15:0] dly;
  } rtq_row_t;

  localparam int unsigned TC0 = 100;
  localparam int unsigned TC1 = 400;
  // Two microseconds at 25 MHz; the pin reaches the counter 4 cycles late.
  localparam int unsigned SHORT_CYC = 50;
  logic             clk = 1'b0;
  logic             rst_b = 1'b0;
  logic             lf_clk_in = 1'b0;
  logic             sense_stop_in = 1'b0;
  logic             nvm_req = 1'b0;
  logic             flight_done = 1'b0;
  logic [4:0]       addr = '0;
  logic [31:0]      wdata = '0;
  logic             wr = 1'b0;
  logic             rd = 1'b0;
  logic [31:0]      rdata;
  logic             discharge_en;
  logic [1:0]       port_sel;
  logic             hs_osc_en;
  logic             flight_go;
  logic             inv = 1'b1;
  logic [3:0][15:0] dly = '0;
  logic [15:0]      dcnt = '0;
  logic [15:0]      win_lim = 16'h0190;
  logic             win_end;
  int               n_win = 0;
  logic [4:0]       fl_sh = '0;
  int               miscompares = 0;
  int               n_compared = 0;
  int               cycles = 0;
  int               n_go = 0;
  rtq_row_t         rows [4];

  rtq_if link ();
  rtq_dev #(.TCYC0_CYC(TC0), .TCYC1_CYC(TC1)) rtq_dev_inst (
    .clk(clk), .rst_b(rst_b), .link(link), .lf_clk_in(lf_clk_in),
    .sense_stop_in(sense_stop_in), .discharge_en(discharge_en),
    .port_sel(port_sel), .nvm_req(nvm_req), .flight_done(flight_done),
    .hs_osc_en(hs_osc_en), .flight_go(flight_go));
  rtq_host rtq_host_inst (
    .clk(clk), .rst_b(rst_b), .link(link), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));
  rtq_asserts #(.TCYC0_CYC(TC0), .TCYC1_CYC(TC1)) rtq_asserts_inst (
    .clk(clk), .rst_b(rst_b), .cmd_valid(link.cmd_valid),
    .cmd_op(link.cmd_op), .cfg(link.cfg), .busy(link.busy),
    .done_flag(link.done_flag), .discharge_en(discharge_en),
    .port_sel(port_sel), .hs_osc_en(hs_osc_en), .nvm_req(nvm_req));

  always #20 clk = ~clk;
  always #15259 lf_clk_in = ~lf_clk_in;

  // ==========================================================================
  // Sensor front end, flight echo and run limit
  // ==========================================================================
  // A zero delay never stops the window, which models an open sensor.
  // A window restarts once its stop has reached the counter, four cycles
  // after the pin moved, or once the cycle limit has run out.
  assign win_end = discharge_en === 1'b1 && (dcnt == win_lim - 16'h1 ||
                   (sense_stop_in != inv && dcnt == dly[port_sel] + 16'h4));
  always @(posedge clk) begin
    if (discharge_en !== 1'b1 || win_end) begin
      dcnt          <= 16'h0;
      sense_stop_in <= inv;
    end else begin
      dcnt <= dcnt + 16'h1;
      if (dly[port_sel] != 16'h0 && dcnt == dly[port_sel]) begin
        sense_stop_in <= ~inv;
      end
    end
    if (link.cmd_valid === 1'b1) n_win <= 0;
    else if (win_end) n_win <= n_win + 1;
    fl_sh <= {fl_sh[3:0], flight_go};
    flight_done <= fl_sh[4];
    if (flight_go === 1'b1) n_go <= n_go + 1;
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      miscompares = miscompares + 1;
      end_sim();
    end
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string nm, input logic [31:0] lo,
                         input logic [31:0] hi, input logic [31:0] got);
    n_compared++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      miscompares++;
      $display("ERROR %s expected %h to %h seen %h", nm, lo, hi, got);
    end
  endtask : chk_rng

  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // Start enable stays set so that stops are honoured throughout.
  function automatic logic [31:0] cfg_word(rtq_row_t r, logic [2:0] osc);
    return {20'h0, 1'b1, osc, r.iv, 3'h0, r.po, r.pc, r.tc, r.dm};
  endfunction : cfg_word

  task automatic wait_done();
    repeat (4) @(posedge clk);
    while (link.done_flag !== 1'b1) @(posedge clk);
  endtask : wait_done

  task automatic check_res(rtq_row_t r);
    logic [31:0] v;
    int          d;
    int          lim;
    lim = r.tc ? TC1 : TC0;
    for (int p = 0; p < 4; p++) begin
      if (!r.pc && (p[1] != r.po)) continue;
      rd_reg(5'h10 + 5'(4 * p), v);
      d = r.dly[p];
      if (d == 0 || d + 4 >= lim) chk("open result", 32'hFFFFFFFF, v);
      else if (d + 4 < SHORT_CYC) chk("short result", 32'h0, v);
      else chk_rng("port result", d, d + 8, v);
    end
  endtask : check_res

  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    logic [31:0] v;
    rows = '{
      '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1,
        {16'h0000, 16'h000A, 16'h012C, 16'h00C8}},
      '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0,
        {16'h005A, 16'h0096, 16'h0014, 16'h003C}},
      '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1,
        {16'h0000, 16'h0000, 16'h001E, 16'h0078}},
      '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1,
        {16'h015E, 16'h004D, 16'h0000, 16'h0000}}};
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd_reg(5'h00, v);
    chk("config reset", 32'h00000A82, v);
    rd_reg(5'h08, v);
    chk("status reset", 32'h0, v);
    rd_reg(5'h0C, v);
    chk("unmapped read", 32'h0, v);
    foreach (rows[i]) begin
      inv     <= rows[i].iv;
      dly     <= rows[i].dly;
      win_lim <= rows[i].tc ? 16'(TC1) : 16'(TC0);
      wr_reg(5'h00, cfg_word(rows[i], 3'h1));
      wr_reg(5'h04, 32'h1);
      wait_done();
      chk("windows", (rows[i].dm ? 32'h8 : 32'h2) +
          (rows[i].pc ? 32'h4 : 32'h2), 32'(n_win));
      check_res(rows[i]);
    end
    // Gated oscillator; new settings and a second start while busy.
    inv     <= rows[0].iv;
    dly     <= rows[0].dly;
    win_lim <= rows[0].tc ? 16'(TC1) : 16'(TC0);
    wr_reg(5'h00, cfg_word(rows[0], 3'h2));
    wr_reg(5'h04, 32'h1);
    repeat (40) @(posedge clk);
    wr_reg(5'h00, cfg_word(rows[3], 3'h2));
    wr_reg(5'h04, 32'h1);
    wait_done();
    repeat (3) @(posedge clk);
    chk("osc after run", 32'h0, {31'h0, hs_osc_en});
    check_res(rows[0]);
    rd_reg(5'h08, v);
    chk("status done", 32'h2, v);
    wr_reg(5'h00, cfg_word(rows[0], 3'h0));
    nvm_req <= 1'b1;
    repeat (6) @(posedge clk);
    chk("osc on request", 32'h1, {31'h0, hs_osc_en});
    nvm_req <= 1'b0;
    repeat (6) @(posedge clk);
    chk("osc off", 32'h0, {31'h0, hs_osc_en});
    wr_reg(5'h00, cfg_word(rows[0], 3'h1));
    wr_reg(5'h04, 32'h3);
    wait_done();
    chk("flight starts", 32'h1, 32'(n_go));
    // Reset in the middle of a run.
    wr_reg(5'h04, 32'h1);
    repeat (200) @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd_reg(5'h10, v);
    chk("result after reset", 32'h0, v);
    rd_reg(5'h08, v);
    chk("status after reset", 32'h0, v);
    end_sim();
  end
endmodule : rtq_test
